// [design/iop_pkg.sv]
// Constants for the pin-level port and external bus logic.
// Assumes one 20 MHz core clock and a core that supplies latch and bus values.
package iop_pkg;
    localparam int PORT_W = 8;
    localparam int CLOCK_NS = 50;
    localparam int MACHINE_CYCLE_NS = 600;
    localparam int MC_CYCLES = (MACHINE_CYCLE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int RESET_MC = 3;
    localparam logic [7:0] RESET_QUAL_CYCLES = 8'(RESET_MC * MC_CYCLES);
    localparam logic [7:0] LATCH_RESET = 8'h_FF;
    localparam logic [15:0] SPLIT_LIMIT = 16'h_1FFF;
    // Port 1 alternate functions
    localparam int P1_GRX = 0;
    localparam int P1_GTX = 1;
    localparam int P1_DEN = 2;
    localparam int P1_TXC = 3;
    localparam int P1_RXC = 4;
    localparam int P1_HOLD = 5;
    localparam int P1_HACK = 6;
    // Port 3 alternate functions
    localparam int P3_URX = 0;
    localparam int P3_UTX = 1;
    localparam int P3_IRQ0 = 2;
    localparam int P3_IRQ1 = 3;
    localparam int P3_TM0 = 4;
    localparam int P3_TM1 = 5;
    localparam int P3_WR = 6;
    localparam int P3_RD = 7;
    typedef enum logic [2:0] {
        IOP_RUN = 3'b001,
        IOP_COUNT = 3'b010,
        IOP_HELD = 3'b100
    } iop_rst_e;
endpackage

// [design/iop_reset_qual.sv]
// Qualifies the reset pin: reset is taken after three whole machine cycles low.
// Assumes the pin is synchronous to the clock.
`timescale 1ns/10ps
module iop_reset_qual (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clockEnable,
    // Pin and result
    input wire logic resetPin_n,
    output logic inReset
);
    import iop_pkg::*;
    iop_rst_e state;
    logic [7:0] count;

    // ==========================================
    // Qualifying counter
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= IOP_RUN;
            count <= 8'h_00;
            inReset <= 1'b0;
        end else if (clockEnable) begin
            case (state)
                IOP_RUN: begin
                    inReset <= 1'b0;
                    if (!resetPin_n) begin
                        state <= IOP_COUNT;
                        count <= 8'h_01;
                    end
                end
                IOP_COUNT: begin
                    if (resetPin_n) begin
                        state <= IOP_RUN;
                    end else if (count == RESET_QUAL_CYCLES - 8'h_01) begin
                        state <= IOP_HELD;
                        inReset <= 1'b1;
                    end else begin
                        count <= count + 8'h_01;
                    end
                end
                IOP_HELD: begin
                    if (resetPin_n) begin
                        state <= IOP_RUN;
                        inReset <= 1'b0;
                    end
                end
                default: begin
                    state <= IOP_RUN;
                    inReset <= 1'b0;
                end
            endcase
        end
    end
endmodule

// [design/iop_port_logic.sv]
// Pin logic of ports 0 to 4, fetch strobe choice, address latch strobe.
// Assumes a core that gives latch writes, bus cycle info and alternate outputs.
// How it works
// - Access select ignored without extra ports or with alternate bus enable low; else it steers fetch location.
// - Alternate bus enable high with extra ports: alternate program strobe reads program memory, with access select high only up to SPLIT_LIMIT.
// - Alternate bus enable low: primary program strobe reads program memory.
// - Reset taken only after reset pin low three machine cycles.
// - Reset does not cut off a serial channel frame in progress.
// - Address latch strobe marks low address byte on multiplexed bus.
// - Bus enable with access select picks ports 0,2 or ports 5,6.
// - Port 0 is open-drain, 8 bits, bit-writable, usable as floating inputs.
// - Port 0 carries multiplexed low address/data byte when its bus is used.
// - Port 2 carries high address byte when its bus is used.
// - Latch one makes pin an input with weak pull-up.
// - Ports 1 to 4 show latch bits; bit-writable 8-bit latches.
// - Port 1 bits 0 to 6 carry serial channel and hold alternates.
// - Port 3 bits carry UART, interrupts, timers, data strobes.
`timescale 1ns/10ps
module iop_port_logic (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clockEnable,
    // Strap and board inputs
    input wire logic hasExtraPorts,
    input wire logic external_access_select,
    input wire logic alt_bus_enable,
    input wire logic resetPin_n,
    // Core latch writes: byte write or single-bit write
    input wire logic [4:0] latchWrite,
    input wire logic [4:0] bitWrite,
    input wire logic [2:0] bitIndex,
    input wire logic bitValue,
    input wire logic [7:0] writeData,
    // Core external bus cycle
    input wire logic busCycle,
    input wire logic busFetch,
    input wire logic busAddrPhase,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic [15:0] busAddr,
    input wire logic [7:0] busWriteData,
    // Alternate outputs from peripherals
    input wire logic serial_channel_tx,
    input wire logic line_driver_enable,
    input wire logic dma_hold_ack,
    input wire logic serialBusy,
    input wire logic uartTx,
    // Pins
    input wire logic [iop_pkg::PORT_W-1:0] port0In,
    output logic [iop_pkg::PORT_W-1:0] port0Out,
    output logic [iop_pkg::PORT_W-1:0] port0Oe_n,
    input wire logic [iop_pkg::PORT_W-1:0] port1In,
    output logic [iop_pkg::PORT_W-1:0] port1Out,
    output logic [iop_pkg::PORT_W-1:0] port1Oe_n,
    input wire logic [iop_pkg::PORT_W-1:0] port2In,
    output logic [iop_pkg::PORT_W-1:0] port2Out,
    output logic [iop_pkg::PORT_W-1:0] port2Oe_n,
    input wire logic [iop_pkg::PORT_W-1:0] port3In,
    output logic [iop_pkg::PORT_W-1:0] port3Out,
    output logic [iop_pkg::PORT_W-1:0] port3Oe_n,
    input wire logic [iop_pkg::PORT_W-1:0] port4In,
    output logic [iop_pkg::PORT_W-1:0] port4Out,
    output logic [iop_pkg::PORT_W-1:0] port4Oe_n,
    // Strobes
    output logic addressLatchStrobe,
    output logic program_read_strobe_n,
    output logic alt_program_read_strobe_n,
    output logic fetchOnAltPorts,
    output logic deviceReset,
    output logic serialKeepsRunning,
    // Sampled pins to the core
    output logic [7:0] port0Read,
    output logic [7:0] port1Read,
    output logic [7:0] port2Read,
    output logic [7:0] port3Read,
    output logic [7:0] port4Read,
    output logic [7:0] busReadData,
    // Alternate inputs to peripherals
    output logic serial_channel_rx,
    output logic external_tx_clock_n,
    output logic external_rx_clock_n,
    output logic dma_hold_request_n,
    output logic uartRx,
    output logic external_irq_zero_n,
    output logic external_irq_one_n,
    output logic timer_zero_input,
    output logic timer_one_input
);
    import iop_pkg::*;

    logic [7:0] latch [5];
    logic inReset;
    logic altSide;
    logic lowBusActive;
    logic [7:0] port1AltMask;
    logic [7:0] port3AltMask;

    // Byte write wins over a bit write to the same port
    function automatic logic [7:0] update_latch(input logic [7:0] old, input logic byteWr,
            input logic bitWr, input logic [2:0] idx, input logic val, input logic [7:0] data);
        logic [7:0] result;
        result = old;
        if (byteWr) begin
            result = data;
        end else if (bitWr) begin
            result[idx] = val;
        end
        return result;
    endfunction

    // Quasi-bidirectional pin: drive low strongly, float to the pull-up for one
    function automatic logic [7:0] drive_low_enable(input logic [7:0] value);
        return value;
    endfunction

    // All-ones mask with one bit cleared while that alternate output is low
    function automatic logic [7:0] alt_mask(input int position, input logic value);
        logic [7:0] mask;
        mask = '1;
        mask[position] = value;
        return mask;
    endfunction

    // ==========================================
    // Reset qualification
    // Short low pulses on the reset pin are ignored
    iop_reset_qual resetQual (
        .clock(clock),
        .arst_n(arst_n),
        .clockEnable(clockEnable),
        .resetPin_n(resetPin_n),
        .inReset(inReset)
    );

    // ==========================================
    // Port latches
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 5; i++) begin
                latch[i] <= LATCH_RESET;
            end
        end else if (clockEnable) begin
            for (int i = 0; i < 5; i++) begin
                // Pin reset sets every latch, so pins go back to inputs unless an alternate output on port 1 or 3 still drives them low
                if (inReset) begin
                    latch[i] <= LATCH_RESET;
                end else begin
                    latch[i] <= update_latch(latch[i], latchWrite[i], bitWrite[i],
                        bitIndex, bitValue, writeData);
                end
            end
        end
    end

    // ==========================================
    // Fetch port and strobe choice
    always_comb begin
        if (!hasExtraPorts) begin
            altSide = 1'b0;
        end else if (!alt_bus_enable) begin
            altSide = 1'b0;
        end else if (external_access_select) begin
            altSide = (busAddr <= SPLIT_LIMIT);
        end else begin
            altSide = 1'b1;
        end
    end

    // A fetch steered to ports 5 and 6 leaves ports 0 and 2 to their latches
    assign lowBusActive = busCycle && !inReset && !(busFetch && altSide);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            program_read_strobe_n <= 1'b1;
            alt_program_read_strobe_n <= 1'b1;
            addressLatchStrobe <= 1'b0;
            fetchOnAltPorts <= 1'b0;
            deviceReset <= 1'b0;
            serialKeepsRunning <= 1'b0;
        end else if (clockEnable) begin
            program_read_strobe_n <= !(busCycle && busFetch && !altSide && !busAddrPhase
                && !inReset);
            alt_program_read_strobe_n <= !(busCycle && busFetch && altSide && !busAddrPhase
                && !inReset);
            addressLatchStrobe <= busCycle && busAddrPhase && !inReset;
            fetchOnAltPorts <= busCycle && busFetch && altSide;
            deviceReset <= inReset;
            // Reset only flags the serial channel; a frame in progress runs on
            serialKeepsRunning <= inReset && serialBusy;
        end
    end

    // ==========================================
    // Alternate outputs: the latch must hold one for them to reach the pin
    always_comb begin
        port1AltMask = alt_mask(P1_GTX, serial_channel_tx)
            & alt_mask(P1_DEN, line_driver_enable)
            & alt_mask(P1_HACK, dma_hold_ack);
        port3AltMask = alt_mask(P3_UTX, uartTx)
            & alt_mask(P3_WR, !(lowBusActive && busWrite && !busFetch))
            & alt_mask(P3_RD, !(lowBusActive && busRead && !busFetch));
    end

    // ==========================================
    // Bus pins: ports 0 and 2
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            port0Out <= 8'h_00;
            port0Oe_n <= 8'h_FF;
            port2Out <= 8'h_00;
            port2Oe_n <= 8'h_FF;
        end else if (clockEnable) begin
            if (lowBusActive && (busAddrPhase || busWrite)) begin
                port0Out <= busAddrPhase ? busAddr[7:0] : busWriteData;
                port0Oe_n <= 8'h_00;
            end else if (lowBusActive) begin
                // Read phase: let go of port 0 so the memory can drive it
                port0Out <= 8'h_00;
                port0Oe_n <= 8'h_FF;
            end else begin
                port0Out <= 8'h_00;
                port0Oe_n <= drive_low_enable(latch[0]);
            end
            if (lowBusActive) begin
                port2Out <= busAddr[15:8];
                port2Oe_n <= 8'h_00;
            end else begin
                port2Out <= 8'h_00;
                port2Oe_n <= drive_low_enable(latch[2]);
            end
        end
    end

    // ==========================================
    // Quasi-bidirectional ports 1, 3 and 4
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            port1Out <= 8'h_00;
            port1Oe_n <= 8'h_FF;
            port3Out <= 8'h_00;
            port3Oe_n <= 8'h_FF;
            port4Out <= 8'h_00;
            port4Oe_n <= 8'h_FF;
        end else if (clockEnable) begin
            port1Out <= 8'h_00;
            port1Oe_n <= drive_low_enable(latch[1] & port1AltMask);
            port3Out <= 8'h_00;
            port3Oe_n <= drive_low_enable(latch[3] & port3AltMask);
            port4Out <= 8'h_00;
            port4Oe_n <= drive_low_enable(latch[4]);
        end
    end

    // ==========================================
    // Pin sampling; pins are synchronous, so one register stage is enough
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            port0Read <= 8'h_FF;
            port1Read <= 8'h_FF;
            port2Read <= 8'h_FF;
            port3Read <= 8'h_FF;
            port4Read <= 8'h_FF;
            busReadData <= 8'h_00;
        end else if (clockEnable) begin
            port0Read <= port0In;
            port1Read <= port1In;
            port2Read <= port2In;
            port3Read <= port3In;
            port4Read <= port4In;
            busReadData <= port0In;
        end
    end

    // ==========================================
    // Alternate inputs to the peripherals
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            serial_channel_rx <= 1'b1;
            external_tx_clock_n <= 1'b1;
            external_rx_clock_n <= 1'b1;
            dma_hold_request_n <= 1'b1;
            uartRx <= 1'b1;
            external_irq_zero_n <= 1'b1;
            external_irq_one_n <= 1'b1;
            timer_zero_input <= 1'b1;
            timer_one_input <= 1'b1;
        end else if (clockEnable) begin
            serial_channel_rx <= port1In[P1_GRX];
            external_tx_clock_n <= port1In[P1_TXC];
            external_rx_clock_n <= port1In[P1_RXC];
            dma_hold_request_n <= port1In[P1_HOLD];
            uartRx <= port3In[P3_URX];
            external_irq_zero_n <= port3In[P3_IRQ0];
            external_irq_one_n <= port3In[P3_IRQ1];
            timer_zero_input <= port3In[P3_TM0];
            timer_one_input <= port3In[P3_TM1];
        end
    end
endmodule

// [verif/iop_port_logic_properties.sv]
// Concurrent checks on the strobes, bus bytes and latches of iop_port_logic.
// Assumes it is bound into that module and sees only its ports.
`timescale 1ns/10ps
module iop_port_logic_properties (
    // Clock and reset
    input wire logic clock, arst_n, clockEnable,
    // Straps, reset pin and core side
    input wire logic hasExtraPorts, external_access_select, alt_bus_enable, resetPin_n,
    input wire logic [4:0] latchWrite,
    input wire logic [7:0] writeData,
    input wire logic busCycle, busAddrPhase, serialBusy, uartTx,
    input wire logic [15:0] busAddr,
    // Pins and strobes
    input wire logic [iop_pkg::PORT_W-1:0] port0Out, port2Out, port3Oe_n, port4Oe_n,
    input wire logic addressLatchStrobe, program_read_strobe_n, alt_program_read_strobe_n,
    input wire logic fetchOnAltPorts, deviceReset, serialKeepsRunning
);
    import iop_pkg::*;
    logic [7:0] lowCount;
    logic [15:0] addrQ;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ==========================================
    // Consecutive low samples of the reset pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lowCount <= 8'h00;
        end else if (clockEnable) begin
            lowCount <= resetPin_n ? 8'h00 : lowCount + 8'(lowCount != 8'hff);
        end
    end
    always_ff @(posedge clock) begin
        if (clockEnable) begin
            addrQ <= busAddr;
        end
    end
    // ==========================================
    // Properties
    chk_primary_idle: assert property (
        (hasExtraPorts && alt_bus_enable && !external_access_select) [*3] |-> program_read_strobe_n)
        else $error("primary strobe active on alternate bus");
    chk_alt_idle: assert property ((!alt_bus_enable) [*3] |-> alt_program_read_strobe_n)
        else $error("alternate strobe active with bus enable low");
    chk_access_ignored: assert property (
        (!hasExtraPorts) [*3] |-> alt_program_read_strobe_n && !fetchOnAltPorts)
        else $error("alternate ports used without extra ports");
    chk_latch_strobe: assert property (
        busCycle && busAddrPhase && !deviceReset |=> addressLatchStrobe)
        else $error("no address latch strobe in address phase");
    chk_bus_address: assert property (
        busCycle && busAddrPhase && !hasExtraPorts && !deviceReset
        |=> port0Out == addrQ[7:0] && port2Out == addrQ[15:8])
        else $error("address bytes wrong on ports 0 and 2");
    chk_reset_early: assert property ($rose(deviceReset) |-> lowCount > RESET_QUAL_CYCLES)
        else $error("reset taken too early");
    chk_reset_taken: assert property (lowCount > RESET_QUAL_CYCLES |-> deviceReset)
        else $error("reset not taken");
    chk_serial_kept: assert property (
        serialBusy && deviceReset ##1 serialBusy && deviceReset |-> serialKeepsRunning)
        else $error("serial channel stopped by reset");
    chk_latch_pins: assert property (
        latchWrite[4] && clockEnable && !deviceReset && lowCount == 8'h00
        ##1 !deviceReset && clockEnable ##1 !deviceReset
        |-> port4Oe_n == $past(writeData, 2))
        else $error("port 4 pins do not follow latch");
    chk_alt_and: assert property ((!uartTx && !deviceReset) [*3] |-> !port3Oe_n[1])
        else $error("low alternate output not on pin");
    cover property ($rose(deviceReset));
    cover property (!alt_program_read_strobe_n && fetchOnAltPorts);
    cover property (!program_read_strobe_n);
endmodule
bind iop_port_logic iop_port_logic_properties chk (.*);

// [verif/iop_ext_mem.sv]
// External program memory on the multiplexed bus of ports 0 and 2.
// Assumes the bench resolves the pin levels it sees and it drives.
`timescale 1ns/10ps
module iop_ext_mem (
    // Clock
    input wire logic clock,
    // Bus pins
    input wire logic ale,
    input wire logic readStrobe_n,
    input wire logic [7:0] lowPins,
    input wire logic [7:0] highPins,
    output logic [7:0] dataOut,
    output logic drive
);
    logic [15:0] addr;
    // Address held from the latch strobe
    always_ff @(posedge clock) begin
        if (ale) begin
            addr <= {highPins, lowPins};
        end
    end
    assign drive = !readStrobe_n;
    assign dataOut = addr[7:0] ^ addr[15:8] ^ 8'h5a;
endmodule

// [verif/iop_port_logic_tb.sv]
// Self-checking bench for iop_port_logic with an external program memory.
// Assumes the package, the design and the memory model compile first.
`timescale 1ns/10ps
module iop_port_logic_tb;
    import iop_pkg::*;
    logic clock = 0, arst_n = 0, clockEnable = 1, hasExtraPorts = 0, resetPin_n = 1;
    logic external_access_select = 0, alt_bus_enable = 0, bitValue = 0, serialBusy = 0;
    logic busCycle = 0, busFetch = 0, busAddrPhase = 0, busRead = 0, busWrite = 0;
    logic serial_channel_tx = 1, line_driver_enable = 1, dma_hold_ack = 1, uartTx = 1;
    logic [4:0] latchWrite = 5'h00, bitWrite = 5'h00;
    logic [2:0] bitIndex = 3'h0;
    logic [15:0] busAddr = 16'h0000;
    logic [7:0] writeData = 8'h00, busWriteData = 8'h00, busReadData, memData, p0Last, d;
    logic addressLatchStrobe, program_read_strobe_n, alt_program_read_strobe_n, fetchOnAltPorts;
    logic deviceReset, serialKeepsRunning, serial_channel_rx, external_tx_clock_n, memDrive;
    logic external_rx_clock_n, dma_hold_request_n, uartRx, external_irq_zero_n;
    logic external_irq_one_n, timer_zero_input, timer_one_input;
    logic [7:0] pin [5], oe [5], out [5], rd [5], ext [5], lat [5];
    logic [3:0] alt4;
    int n_mismatch = 0, checked = 0, cycles = 0, k;
    iop_port_logic dut (.*,
        .port0In(pin[0]), .port0Out(out[0]), .port0Oe_n(oe[0]), .port0Read(rd[0]),
        .port1In(pin[1]), .port1Out(out[1]), .port1Oe_n(oe[1]), .port1Read(rd[1]),
        .port2In(pin[2]), .port2Out(out[2]), .port2Oe_n(oe[2]), .port2Read(rd[2]),
        .port3In(pin[3]), .port3Out(out[3]), .port3Oe_n(oe[3]), .port3Read(rd[3]),
        .port4In(pin[4]), .port4Out(out[4]), .port4Oe_n(oe[4]), .port4Read(rd[4]));
    iop_ext_mem mem (.clock(clock), .ale(addressLatchStrobe), .readStrobe_n(program_read_strobe_n),
        .lowPins(pin[0]), .highPins(pin[2]), .dataOut(memData), .drive(memDrive));
    // ==========================================
    // Pin levels: pull-ups on ports 1 to 4, floating port 0 shows no stale value
    for (genvar p = 1; p < 5; p++) begin : gPin
        assign pin[p] = (~oe[p] & out[p]) | (oe[p] & ext[p]);
    end
    assign pin[0] = (~oe[0] & out[0]) | (oe[0] & (memDrive ? memData : ~p0Last));
    always @(posedge clock) p0Last <= pin[0];
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end
    // ==========================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input int p, input logic [7:0] v);
        @(posedge clock);
        latchWrite[p] <= 1'b1;
        writeData <= v;
        lat[p] = v;
        @(posedge clock);
        latchWrite <= 5'h00;
        bitWrite <= 5'h00;
    endtask
    task automatic fetch(input logic x, input logic b, input logic a, input logic [15:0] ad);
        logic useAlt, sawAle, sawOk, sawBad, sawData, onAlt;
        logic [7:0] hi;
        useAlt = x && b && (!a || ad <= SPLIT_LIMIT);
        {sawAle, sawOk, sawBad, sawData, onAlt, hi} = '0;
        @(posedge clock);
        {hasExtraPorts, alt_bus_enable, external_access_select} <= {x, b, a};
        tick(3);
        {busCycle, busFetch, busAddrPhase, busAddr} <= {3'b111, ad};
        repeat (7) begin
            @(posedge clock);
            busAddrPhase <= 0;
            #1;
            sawAle |= addressLatchStrobe;
            if (addressLatchStrobe) hi = out[2];
            sawOk |= useAlt ? !alt_program_read_strobe_n : !program_read_strobe_n;
            sawBad |= useAlt ? !program_read_strobe_n : !alt_program_read_strobe_n;
            onAlt |= fetchOnAltPorts;
            sawData |= busReadData === (ad[7:0] ^ ad[15:8] ^ 8'h5a);
        end
        @(posedge clock);
        {busCycle, busFetch} <= 2'b00;
        check(sawAle, 1, "latch strobe");
        check({sawOk, sawBad, onAlt}, {2'b10, useAlt}, "fetch strobe");
        if (!useAlt) check({hi, 7'h00, sawData}, {ad[15:8], 8'h01}, "fetch bytes");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        void'($urandom(32'h40ddd58c));
        for (int p = 0; p < 5; p++) begin
            ext[p] = 8'hff;
            lat[p] = 8'hff;
        end
        tick(10);
        arst_n <= 1;
        tick(2);
        #1;
        for (int p = 0; p < 5; p++) check(oe[p], 8'hff, "pins after reset");
        $display("test reset done");
        for (int i = 0; i < 30; i++) begin
            k = i % 5;
            d = 8'($urandom);
            @(posedge clock);
            ext[k] <= 8'($urandom);
            if (i % 2 == 1) begin
                {bitWrite[k], bitIndex, bitValue} <= {1'b1, d[2:0], d[7]};
                lat[k][d[2:0]] = d[7];
            end else begin
                latchWrite[k] <= 1'b1;
                writeData <= d;
                lat[k] = d;
            end
            @(posedge clock);
            {latchWrite, bitWrite} <= 10'h000;
            tick(2);
            #1;
            check(oe[k], lat[k], "latch on pins");
            if (k > 0) check(rd[k], lat[k] & ext[k], "pin read back");
        end
        $display("test latches done");
        wr(1, 8'hff);
        wr(3, 8'hff);
        for (int i = 0; i < 12; i++) begin
            alt4 = 4'($urandom);
            @(posedge clock);
            {ext[1], ext[3]} <= 16'($urandom);
            {serial_channel_tx, line_driver_enable, dma_hold_ack, uartTx} <= alt4;
            tick(3);
            #1;
            check({oe[1][1], oe[1][2], oe[1][6], oe[3][1]}, alt4, "alternate out");
            d = {ext[1][0], ext[1][3], ext[1][4], ext[1][5], 4'h0};
            check({serial_channel_rx, external_tx_clock_n, external_rx_clock_n,
                dma_hold_request_n, 4'h0}, d, "port 1 alternates");
            d = {ext[3][0], ext[3][2], ext[3][3], ext[3][4], ext[3][5], 3'h0};
            check({uartRx, external_irq_zero_n, external_irq_one_n, timer_zero_input,
                timer_one_input, 3'h0}, d, "port 3 alternates");
        end
        @(posedge clock);
        {serial_channel_tx, line_driver_enable, dma_hold_ack, uartTx} <= 4'hf;
        $display("test alternates done");
        @(posedge clock);
        {resetPin_n, serialBusy} <= 2'b01;
        tick(RESET_QUAL_CYCLES - 1);
        #1;
        check(deviceReset, 0, "reset too early");
        tick(2);
        #1;
        check({deviceReset, serialKeepsRunning}, 2'b11, "reset taken");
        wr(4, 8'h00);
        tick(2);
        #1;
        check(oe[4], 8'hff, "write during reset");
        @(posedge clock);
        {resetPin_n, serialBusy} <= 2'b10;
        tick(3);
        #1;
        check(deviceReset, 0, "reset released");
        $display("test reset pin done");
        for (int i = 0; i < 10; i++) begin
            k = i < 8 ? i : 7;
            fetch(k[0], k[1], k[2], i == 8 ? 16'h1fff : i == 9 ? 16'h2000 : 16'($urandom));
        end
        $display("test fetch done");
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            @(posedge clock);
            {busCycle, busWrite, busRead, busWriteData} <= {1'b1, i == 0, i == 1, d};
            tick(2);
            #1;
            check(oe[3][7:6], i == 0 ? 2'b10 : 2'b01, "data strobes");
            check({oe[0], out[0]}, i == 0 ? {8'h00, d} : 16'hff00, "data byte");
            @(posedge clock);
            {busCycle, busWrite, busRead} <= 3'b000;
        end
        @(posedge clock);
        {clockEnable, latchWrite[4], writeData} <= {2'b01, 8'h00};
        tick(3);
        #1;
        check(oe[4], 8'hff, "latch frozen");
        @(posedge clock);
        {clockEnable, latchWrite} <= 6'h20;
        $display("test data bus done");
        wr(2, 8'h0f);
        @(posedge clock);
        arst_n <= 0;
        tick(3);
        arst_n <= 1;
        tick(2);
        #1;
        check(oe[2], 8'hff, "latch after second reset");
        $display("test second reset done");
        results();
    end
endmodule
